// File: design/assi_pkg.sv
package assi_pkg;

    // Register map
    localparam logic [7:0]  SEL_REG_OFFSET   = 8'h00;
    localparam logic [7:0]  CTL_REG_OFFSET   = 8'h04;
    localparam logic [7:0]  STAT_REG_OFFSET  = 8'h08;
    localparam logic [31:0] SEL_RESET        = 32'h0000_0000;
    localparam logic [31:0] CTL_RESET        = 32'h0000_0000;

    // Input-select field layout: step n at bit 4*n
    localparam int          STEP_COUNT       = 8;
    localparam int          FIELD_STRIDE     = 4;
    localparam int          FIELD_WIDTH      = 2;
    localparam logic [31:0] SEL_WRITE_MASK   = 32'h3333_3333;

    // Per-step control nibble layout inside the control register
    localparam int          CTL_END_POS      = 1;
    localparam int          CTL_TS_POS       = 3;

    // Status register layout
    localparam int          STAT_BUSY_POS    = 0;
    localparam int          STAT_STEP_POS    = 4;

    // Channel code sent for the internal temperature sensor
    localparam logic [2:0]  TEMP_CHANNEL     = 3'h4;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_REQ  = 2'b01,
        SEQ_WAIT = 2'b10
    } assi_state_type;

endpackage

// File: design/assi_top.sv
`timescale 1ns/1ps

module assi_top
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        seq_start,
    output logic             conv_req,
    output logic      [2:0]  conv_channel,
    output logic      [2:0]  conv_step,
    input  wire logic        conv_done,
    output logic             seq_done
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [31:0]                 sel_ff;
    logic [31:0]                 ctl_ff;
    logic [31:0]                 rdata_ff;
    assi_pkg::assi_state_type    state_ff;
    logic [2:0]                  step_ff;
    logic                        req_ff;
    logic [2:0]                  chan_ff;
    logic [2:0]                  cstep_ff;
    logic                        done_ff;

    // Input-select register; gap bits never store
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sel_ff <= assi_pkg::SEL_RESET;
        else if (reg_wr && reg_addr == assi_pkg::SEL_REG_OFFSET)
            sel_ff <= reg_wdata & assi_pkg::SEL_WRITE_MASK;
    end

    // Per-step control register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ctl_ff <= assi_pkg::CTL_RESET;
        else if (reg_wr && reg_addr == assi_pkg::CTL_REG_OFFSET)
            ctl_ff <= reg_wdata;
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_ff <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                assi_pkg::SEL_REG_OFFSET:  rdata_ff <= sel_ff;
                assi_pkg::CTL_REG_OFFSET:  rdata_ff <= ctl_ff;
                assi_pkg::STAT_REG_OFFSET:
                    rdata_ff <= {25'h0, step_ff, 3'h0, state_ff != assi_pkg::SEQ_IDLE};
                default:                   rdata_ff <= 32'h0000_0000;
            endcase
        end
        else
            rdata_ff <= 32'h0000_0000;
    end

    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    logic [1:0] cur_sel;
    logic       cur_ts;
    logic       cur_end;
    logic [2:0] nxt_chan;

    always_comb
    begin
        cur_sel  = sel_ff[step_ff * assi_pkg::FIELD_STRIDE +: assi_pkg::FIELD_WIDTH];
        cur_ts   = ctl_ff[step_ff * assi_pkg::FIELD_STRIDE + assi_pkg::CTL_TS_POS];
        cur_end  = ctl_ff[step_ff * assi_pkg::FIELD_STRIDE + assi_pkg::CTL_END_POS];
        if (cur_ts)
            nxt_chan = assi_pkg::TEMP_CHANNEL;
        else
            nxt_chan = {1'b0, cur_sel};
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= assi_pkg::SEQ_IDLE;
            step_ff  <= 3'h0;
            req_ff   <= 1'b0;
            chan_ff  <= 3'h0;
            cstep_ff <= 3'h0;
            done_ff  <= 1'b0;
        end
        else
        begin
            req_ff  <= 1'b0;
            done_ff <= 1'b0;
            case (state_ff)
                assi_pkg::SEQ_IDLE:
                    if (seq_start)
                    begin
                        step_ff  <= 3'h0;
                        state_ff <= assi_pkg::SEQ_REQ;
                    end
                assi_pkg::SEQ_REQ:
                begin
                    req_ff   <= 1'b1;
                    chan_ff  <= nxt_chan;
                    cstep_ff <= step_ff;
                    state_ff <= assi_pkg::SEQ_WAIT;
                end
                assi_pkg::SEQ_WAIT:
                    if (conv_done)
                    begin
                        if (cur_end || step_ff == 3'h7)
                        begin
                            done_ff  <= 1'b1;
                            state_ff <= assi_pkg::SEQ_IDLE;
                        end
                        else
                        begin
                            step_ff  <= step_ff + 3'h1;
                            state_ff <= assi_pkg::SEQ_REQ;
                        end
                    end
                default:
                    state_ff <= assi_pkg::SEQ_IDLE;
            endcase
        end
    end

    assign conv_req     = req_ff;
    assign conv_channel = chan_ff;
    assign conv_step    = cstep_ff;
    assign seq_done     = done_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    gap_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sel_ff & ~assi_pkg::SEL_WRITE_MASK) == 32'h0)
        else $error("gap bits of input select not zero");

    sel_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> sel_ff[1:0] == $past(reg_wdata[1:0]))
        else $error("step 1 field did not take write");

    step7_field_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> sel_ff[25:24] == $past(reg_wdata[25:24]))
        else $error("step 7 field did not take write");

    read_back_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> reg_rdata[5:4] == $past(sel_ff[5:4]) && reg_rdata[3:2] == 2'h0)
        else $error("input select read back wrong");

    chan_map_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == assi_pkg::SEQ_REQ && !cur_ts
        |=> conv_req && conv_channel == {1'b0, $past(cur_sel)})
        else $error("channel does not follow field");

    temp_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == assi_pkg::SEQ_REQ && cur_ts
        |=> conv_channel == assi_pkg::TEMP_CHANNEL)
        else $error("temperature step not routed to sensor");

    end_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == assi_pkg::SEQ_WAIT && conv_done && cur_end
        |=> seq_done ##1 !conv_req [*2])
        else $error("request after end of sequence");

    step8_field_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == assi_pkg::SEQ_REQ && step_ff == 3'h7 && !cur_ts
        |=> conv_channel[1:0] == $past(sel_ff[29:28]))
        else $error("step 8 field not used");

    hold_chan_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == assi_pkg::SEQ_WAIT && !$past(state_ff == assi_pkg::SEQ_REQ)
        |-> $stable(conv_channel))
        else $error("channel changed during conversion");

    step2_field_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> sel_ff[5:4] == $past(reg_wdata[5:4]))
        else $error("step 2 field did not take write");

    step3_field_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> sel_ff[9:8] == $past(reg_wdata[9:8]))
        else $error("step 3 field did not take write");

    step4_field_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> sel_ff[13:12] == $past(reg_wdata[13:12]))
        else $error("step 4 field did not take write");

    step5_field_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> sel_ff[17:16] == $past(reg_wdata[17:16]))
        else $error("step 5 field did not take write");

    step6_field_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> sel_ff[21:20] == $past(reg_wdata[21:20]))
        else $error("step 6 field did not take write");

    step8_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> sel_ff[29:28] == $past(reg_wdata[29:28]))
        else $error("step 8 field did not take write");

    sel_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !(reg_wr && reg_addr == assi_pkg::SEL_REG_OFFSET)
        |=> $stable(sel_ff))
        else $error("input select changed without write");

    gap_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> (reg_rdata & ~assi_pkg::SEL_WRITE_MASK) == 32'h0)
        else $error("gap bits read back nonzero");

    read_step1_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> reg_rdata[1:0] == $past(sel_ff[1:0]))
        else $error("step 1 field read back wrong");

    read_step3_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> reg_rdata[9:8] == $past(sel_ff[9:8]))
        else $error("step 3 field read back wrong");

    read_step4_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> reg_rdata[13:12] == $past(sel_ff[13:12]))
        else $error("step 4 field read back wrong");

    read_step5_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> reg_rdata[17:16] == $past(sel_ff[17:16]))
        else $error("step 5 field read back wrong");

    read_step6_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> reg_rdata[21:20] == $past(sel_ff[21:20]))
        else $error("step 6 field read back wrong");

    read_step7_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> reg_rdata[25:24] == $past(sel_ff[25:24]))
        else $error("step 7 field read back wrong");

    read_step8_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == assi_pkg::SEL_REG_OFFSET
        |=> reg_rdata[29:28] == $past(sel_ff[29:28]))
        else $error("step 8 field read back wrong");

    rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
        !reg_rd
        |=> reg_rdata == 32'h0)
        else $error("read data not zero outside read");

    req_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        conv_req
        |=> !conv_req)
        else $error("conversion request longer than one cycle");

    done_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        seq_done
        |=> !seq_done)
        else $error("sequence done longer than one cycle");

    step_index_a: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == assi_pkg::SEQ_REQ
        |=> conv_step == $past(step_ff))
        else $error("request step index wrong");

    chan_range_a: assert property (@(posedge clk) disable iff (!rst_b)
        conv_req
        |-> conv_channel <= assi_pkg::TEMP_CHANNEL)
        else $error("channel code out of range");

    temp_only_a: assert property (@(posedge clk) disable iff (!rst_b)
        conv_req && conv_channel[2]
        |-> conv_channel == assi_pkg::TEMP_CHANNEL)
        else $error("sensor code malformed");

endmodule // assi_top

// File: testbench/assi_chan_model.sv
`timescale 1ns/1ps
module assi_chan_model
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       conv_req,
    input  wire logic [3:0] lat,
    output logic            conv_done
);
    logic [3:0] cnt_ff;
    // Conversion ends lat cycles after each request
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b) cnt_ff <= 4'h0;
        else if (conv_req) cnt_ff <= lat;
        else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
    end
    assign conv_done = (cnt_ff == 4'h1);
endmodule // assi_chan_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic        clk, rst_b, reg_wr, reg_rd, seq_start, conv_req, conv_done, seq_done, rd_d;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, seed, v;
    logic [2:0]  conv_channel, conv_step;
    logic [3:0]  lat;
    logic [31:0] rq[$];
    logic [5:0]  cq[$];
    int          bad_count, n_tests, done_cnt, i;
    assi_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_start(seq_start),
        .conv_req(conv_req), .conv_channel(conv_channel), .conv_step(conv_step),
        .conv_done(conv_done), .seq_done(seq_done));
    assi_chan_model chan_u (.clk(clk), .rst_b(rst_b), .conv_req(conv_req), .lat(lat),
        .conv_done(conv_done));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic finish_test();
        if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic run_seq(input logic [31:0] s, input logic [31:0] c);
        int k;
        int d0;
        wr(8'h00, s);
        wr(8'h04, c);
        for (k = 0; k < 8; k++)
        begin
            cq.push_back({k[2:0], c[4*k+3] ? 3'h4 : {1'b0, s[4*k+:2]}});
            if (c[4*k+1]) break;
        end
        cq.push_back(6'h3f);
        d0 = done_cnt;
        @(posedge clk) seq_start <= 1'b1;
        @(posedge clk) seq_start <= 1'b0;
        @(posedge clk) seq_start <= 1'b1;
        @(posedge clk) seq_start <= 1'b0;
        for (k = 0; k < 300 && done_cnt == d0; k++) @(posedge clk);
        if (done_cnt == d0)
        begin
            bad_count++;
            finish_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        if (rd_d) chk("reg_rdata", rq.pop_front(), reg_rdata);
        rd_d <= reg_rd;
        if (conv_req === 1'b1) chk("conv", {26'h0, cq.pop_front()}, {conv_step, conv_channel});
        if (seq_done === 1'b1)
        begin
            chk("seq_done", {26'h0, cq.pop_front()}, 32'h3f);
            done_cnt++;
        end
    end
    initial
    begin
        {reg_wr, reg_rd, seq_start, rd_d, reg_addr, reg_wdata} = '0;
        seed = 32'h9678;
        lat = 4'h1;
        rst_b = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h00, 32'h0);
        for (i = 0; i < 8; i++)
        begin
            v = $random(seed);
            wr(8'h00, v);
            rd(8'h00, v & 32'h3333_3333);
        end
        rd(8'h0c, 32'h0);
        run_seq($random(seed), 32'h0);
        for (i = 0; i < 10; i++)
        begin
            lat <= 4'h1 + 4'($random(seed) & 3);
            run_seq($random(seed), $random(seed));
        end
        finish_test();
    end
endmodule // tb
